/* File: design/pom_pkg.sv */
/*
  Constants for the packet and power monitor: register map, reset values,
  persistence times and the far-end indicator word layout.
  Assumes a 50 MHz hclk and word-only AHB-Lite accesses.
*/
package pom_pkg;
  localparam int          ADDR_W       = 8;
  localparam logic [7:0]  CTRL_OFS     = 8'h00;
  localparam logic [7:0]  PKT_SET_OFS  = 8'h04;
  localparam logic [7:0]  PKT_CLR_OFS  = 8'h08;
  localparam logic [7:0]  MON_PER_OFS  = 8'h0c;
  localparam logic [7:0]  TX_PER_OFS   = 8'h10;
  localparam logic [7:0]  STATUS_OFS   = 8'h14;
  localparam logic [7:0]  PWR_IND_OFS  = 8'h18;
  localparam logic [7:0]  TX_WORD_OFS  = 8'h1c;
  // Control fields
  localparam int          CTRL_W       = 6;
  localparam int          FAST_EN_B    = 0;
  localparam int          SLOW_EN_B    = 1;
  localparam int          CO_ROLE_B    = 2;
  localparam int          PRO_SUP_B    = 3;
  localparam int          FPO_SUP_B    = 4;
  localparam int          IDLE_B       = 5;
  localparam int          SOFT_CLR_B   = 31;
  localparam logic [5:0]  CTRL_RST     = 6'h07;
  localparam logic [15:0] PKT_SET_RST  = 16'h03e8;
  localparam logic [15:0] PKT_CLR_RST  = 16'h03e8;
  localparam logic [15:0] MON_PER_RST  = 16'h03e8;
  localparam logic [15:0] TX_PER_RST   = 16'h0064;
  // Timebase: one tick per millisecond
  localparam int          CLK_HZ       = 50_000_000;
  localparam int          TICK_US      = 1000;
  localparam int          TICK_CYC     = CLK_HZ / 1_000_000 * TICK_US;
  localparam int          POWER_SET_MS = 2500;
  localparam int          POWER_CLR_MS = 10000;
  localparam logic [15:0] POWER_SET_T  = 16'(POWER_SET_MS * 1000 / TICK_US);
  localparam logic [15:0] POWER_CLR_T  = 16'(POWER_CLR_MS * 1000 / TICK_US);
  // Received power in quarter dB; 6 dB below the reference
  localparam logic [11:0] LOS_MARGIN   = 12'h018;
  // Transmitted far-end indicator word
  localparam int          TXW_W        = 14;
  localparam int          TXW_LOS      = 4;
  localparam int          TXW_LPR      = 6;
  localparam int          TXW_PRO      = 7;
  localparam int          TXW_FPER     = 10;
  localparam int          TXW_FAR_PACKET_LOSS     = 12;
  localparam logic [13:0] IDLE_MASK    = 14'h00d0;
endpackage : pom_pkg

/* File: design/pom_monitor.sv */
/*
  Packet and power primitive monitor with far-end indicator assembly,
  reached over an AHB-Lite slave port.
  Assumes inputs synchronous to hclk, an upstream averager that presents
  received power every 0.1 s, and a transfer block that ships tx_word.
*/
// Chosen here: register access over AHB-Lite and the register addresses.
module pom_monitor #(
  parameter int TICK_CYCLES = pom_pkg::TICK_CYC,
  parameter int NCH         = 2
) (
  input  wire logic                    hclk,
  input  wire logic                    hresetn,
  input  wire logic                    hsel,
  input  wire logic [31:0]             haddr,
  input  wire logic [1:0]              htrans,
  input  wire logic                    hwrite,
  input  wire logic [2:0]              hsize,
  input  wire logic [31:0]             hwdata,
  input  wire logic                    hready,
  output logic      [31:0]             hrdata,
  output logic                         hreadyout,
  output logic                         hresp,
  input  wire logic [NCH-1:0]          fcs_err,
  input  wire logic [NCH-1:0]          far_per_ind,
  input  wire logic [NCH-1:0]          far_pdef_ind,
  input  wire logic [NCH-1:0]          pkt_loss_defect,
  input  wire logic                    supply_fail,
  input  wire logic                    power_switch_off,
  input  wire logic                    far_lpr_ind,
  input  wire logic                    far_pro_ind,
  input  wire logic [3:0]              line_anom,
  input  wire logic                    sef_defect,
  input  wire logic                    ncd_anom,
  input  wire logic                    hec_anom,
  input  wire logic                    steady_state,
  input  wire logic [11:0]             rx_pwr_qdb,
  input  wire logic                    rx_pwr_valid,
  output logic      [NCH-1:0]          packet_error_event,
  output logic      [NCH-1:0]          far_packet_error_event,
  output logic      [NCH-1:0]          packet_error_defect,
  output logic      [NCH-1:0]          far_packet_error_defect,
  output logic                         signal_loss_defect,
  output logic                         supply_loss_event,
  output logic                         supply_loss_failure,
  output logic                         power_off_failure,
  output logic                         far_supply_loss_event,
  output logic                         far_supply_loss_failure,
  output logic                         far_power_off_failure,
  output logic      [5:0]              power_ind,
  output logic      [pom_pkg::TXW_W-1:0] tx_word,
  output logic                         tx_valid
);

  typedef struct packed {
    logic                           ap_val;
    logic                           ap_wr;
    logic [pom_pkg::ADDR_W-1:0]     ap_addr;
    logic [31:0]                    rdata;
    logic [pom_pkg::CTRL_W-1:0]     ctrl;
    logic [15:0]                    pkt_set;
    logic [15:0]                    pkt_clr;
    logic [15:0]                    mon_per;
    logic [15:0]                    tx_per;
    logic [15:0]                    tick_cnt;
    logic                           tick;
    logic [NCH-1:0]                 per_ev;
    logic [NCH-1:0]                 fper_ev;
    logic [NCH-1:0]                 per_def;
    logic [NCH-1:0]                 fper_def;
    logic [NCH-1:0][15:0]           per_cnt;
    logic                           lpr_ev;
    logic                           lpr_fail;
    logic [15:0]                    lpr_cnt;
    logic                           pro_fail;
    logic                           flpr_ev;
    logic                           flpr_arm;
    logic                           flpr_fail;
    logic [15:0]                    flpr_cnt;
    logic                           fpo_fail;
    logic [15:0]                    fpo_cnt;
    logic                           ref_ok;
    logic [11:0]                    ref_pwr;
    logic                           los;
    logic [15:0]                    mon_cnt;
    logic [15:0]                    tx_cnt;
    logic [5:0]                     pwr_acc;
    logic [5:0]                     pwr_ind;
    logic [3:0]                     line_acc;
    logic [pom_pkg::TXW_W-1:0]      tx_word;
    logic                           tx_valid;
  } pom_state_t;

  pom_state_t s_reg;
  pom_state_t s_next;

  ////////////////////////////////////////////////////////////////////////////
  // Persistence timer: flips flag after the input disagrees for the
  // set or clear time in ticks; any agreement restarts the count
  function automatic logic [16:0] pom_persist(
    input logic        act,
    input logic        flag,
    input logic [15:0] cnt,
    input logic        tick,
    input logic [15:0] set_t,
    input logic [15:0] clr_t
  );
    logic [15:0] lim;
    logic [15:0] inc;
    lim = flag ? clr_t : set_t;
    inc = cnt + 16'h0001;
    if (act == flag)
      return {flag, 16'h0000};
    else if (!tick)
      return {flag, cnt};
    else if (inc >= lim)
      return {~flag, 16'h0000};
    else
      return {flag, inc};
  endfunction : pom_persist

  function automatic logic [31:0] pom_rd(input pom_state_t s, input logic [7:0] a);
    logic [31:0] d;
    d = 32'h0000_0000;
    case (a)
      pom_pkg::CTRL_OFS:    d[pom_pkg::CTRL_W-1:0] = s.ctrl;
      pom_pkg::PKT_SET_OFS: d[15:0] = s.pkt_set;
      pom_pkg::PKT_CLR_OFS: d[15:0] = s.pkt_clr;
      pom_pkg::MON_PER_OFS: d[15:0] = s.mon_per;
      pom_pkg::TX_PER_OFS:  d[15:0] = s.tx_per;
      pom_pkg::STATUS_OFS:  d[23:0] = {s.per_ev, s.fper_ev, s.per_def, s.fper_def,
                                       s.los, s.lpr_ev, s.lpr_fail, s.pro_fail,
                                       s.flpr_ev, s.flpr_fail, s.fpo_fail, 9'h000};
      pom_pkg::PWR_IND_OFS: d[5:0] = s.pwr_ind;
      pom_pkg::TX_WORD_OFS: d[pom_pkg::TXW_W-1:0] = s.tx_word;
      default:              d = 32'h0000_0000;
    endcase
    return d;
  endfunction : pom_rd

  ////////////////////////////////////////////////////////////////////////////
  logic        co;
  logic        soft_clr;
  logic [16:0] pt;
  logic [5:0]  pwr_now;
  logic [NCH-1:0] ch_en;
  logic [13:0] txw;

  always_comb
  begin
    s_next   = s_reg;
    soft_clr = 1'b0;
    co       = s_reg.ctrl[pom_pkg::CO_ROLE_B];
    ch_en    = NCH'({s_reg.ctrl[pom_pkg::SLOW_EN_B], s_reg.ctrl[pom_pkg::FAST_EN_B]});
    pt       = 17'h00000;
    pwr_now  = 6'h00;
    txw      = 14'h0000;

    // Bus: zero wait states, data phase follows the taken address phase
    s_next.ap_val = hsel & hready & htrans[1];
    if (s_next.ap_val)
    begin
      s_next.ap_wr   = hwrite;
      s_next.ap_addr = haddr[pom_pkg::ADDR_W-1:0];
      s_next.rdata   = pom_rd(s_reg, haddr[pom_pkg::ADDR_W-1:0]);
    end
    if (s_reg.ap_val && s_reg.ap_wr)
    begin
      case (s_reg.ap_addr)
        pom_pkg::CTRL_OFS:
        begin
          s_next.ctrl = hwdata[pom_pkg::CTRL_W-1:0];
          soft_clr    = hwdata[pom_pkg::SOFT_CLR_B];
        end
        pom_pkg::PKT_SET_OFS: s_next.pkt_set = hwdata[15:0];
        pom_pkg::PKT_CLR_OFS: s_next.pkt_clr = hwdata[15:0];
        pom_pkg::MON_PER_OFS: s_next.mon_per = hwdata[15:0];
        pom_pkg::TX_PER_OFS:  s_next.tx_per  = hwdata[15:0];
        default: ;
      endcase
    end

    // Millisecond tick shared by every timer
    s_next.tick = 1'b0;
    if (s_reg.tick_cnt >= 16'(TICK_CYCLES - 1))
    begin
      s_next.tick_cnt = 16'h0000;
      s_next.tick     = 1'b1;
    end
    else
      s_next.tick_cnt = s_reg.tick_cnt + 16'h0001;

    // Each channel keeps its own event, defect and timer state
    for (int c = 0; c < NCH; c++)
    begin
      if (ch_en[c])
      begin
        s_next.per_ev[c]   = fcs_err[c];
        s_next.fper_ev[c]  = far_per_ind[c];
        s_next.fper_def[c] = far_pdef_ind[c];
        pt = pom_persist(s_reg.per_ev[c], s_reg.per_def[c], s_reg.per_cnt[c],
                         s_reg.tick, s_reg.pkt_set, s_reg.pkt_clr);
        s_next.per_def[c] = pt[16];
        s_next.per_cnt[c] = pt[15:0];
      end
      else
      begin
        s_next.per_ev[c]   = 1'b0;
        s_next.fper_ev[c]  = 1'b0;
        s_next.fper_def[c] = 1'b0;
        s_next.per_def[c]  = 1'b0;
        s_next.per_cnt[c]  = 16'h0000;
      end
    end

    // Signal loss against a reference caught at the first steady-state sample
    if (!steady_state)
    begin
      s_next.ref_ok = 1'b0;
      s_next.los    = 1'b0;
    end
    else if (rx_pwr_valid)
    begin
      if (!s_reg.ref_ok)
      begin
        s_next.ref_ok  = 1'b1;
        s_next.ref_pwr = rx_pwr_qdb;
      end
      else
        s_next.los = (s_reg.ref_pwr >= pom_pkg::LOS_MARGIN) &&
                     (rx_pwr_qdb < s_reg.ref_pwr - pom_pkg::LOS_MARGIN);
    end

    // Near-end power primitives
    s_next.lpr_ev = supply_fail;
    pt = pom_persist(s_reg.lpr_ev, s_reg.lpr_fail, s_reg.lpr_cnt, s_reg.tick,
                     pom_pkg::POWER_SET_T, pom_pkg::POWER_CLR_T);
    s_next.lpr_fail = pt[16];
    s_next.lpr_cnt  = pt[15:0];
    s_next.pro_fail = s_reg.ctrl[pom_pkg::PRO_SUP_B] & power_switch_off;

    // Far-end power primitives, only presented by the central office
    s_next.flpr_ev = co & far_lpr_ind;
    if (s_reg.flpr_ev)
      s_next.flpr_arm = 1'b1;
    pt = pom_persist(s_reg.los & (s_reg.flpr_arm | s_reg.flpr_fail), s_reg.flpr_fail,
                     s_reg.flpr_cnt, s_reg.tick,
                     pom_pkg::POWER_SET_T, pom_pkg::POWER_CLR_T);
    s_next.flpr_fail = co & pt[16];
    s_next.flpr_cnt  = pt[15:0];
    // A fresh far report in the declaring cycle keeps the arm set
    if (pt[16] && !s_reg.flpr_fail && !s_reg.flpr_ev)
      s_next.flpr_arm = 1'b0;

    // Far power-off: declared at once, cleared after a quiet spell, or at once when not central office or not supported
    if (!(co && s_reg.ctrl[pom_pkg::FPO_SUP_B]))
    begin
      s_next.fpo_fail = 1'b0;
      s_next.fpo_cnt  = 16'h0000;
    end
    else if (far_pro_ind)
    begin
      s_next.fpo_fail = 1'b1;
      s_next.fpo_cnt  = 16'h0000;
    end
    else if (s_reg.fpo_fail)
    begin
      pt = pom_persist(s_reg.los, 1'b1, s_reg.fpo_cnt, s_reg.tick,
                       pom_pkg::POWER_CLR_T, pom_pkg::POWER_CLR_T);
      s_next.fpo_fail = pt[16];
      s_next.fpo_cnt  = pt[15:0];
    end

    // Period capture; an event in the capture cycle counts for the closing period
    pwr_now = {s_reg.lpr_ev, s_reg.lpr_fail, s_reg.pro_fail,
               s_reg.flpr_ev, s_reg.flpr_fail, s_reg.fpo_fail};
    s_next.pwr_acc = s_reg.pwr_acc | pwr_now;
    if (s_reg.tick)
    begin
      if (s_reg.mon_cnt + 16'h0001 >= s_reg.mon_per)
      begin
        s_next.mon_cnt = 16'h0000;
        s_next.pwr_ind = s_reg.pwr_acc | pwr_now;
        s_next.pwr_acc = 6'h00;
      end
      else
        s_next.mon_cnt = s_reg.mon_cnt + 16'h0001;
    end

    // Far-end indicator word for the peer
    s_next.line_acc = s_reg.line_acc | line_anom;
    txw = {pkt_loss_defect, s_reg.per_def, hec_anom, ncd_anom,
           s_reg.pro_fail, s_reg.lpr_ev, sef_defect, s_reg.los, s_reg.line_acc};
    s_next.tx_valid = 1'b0;
    if (s_reg.tick)
    begin
      if (s_reg.tx_cnt + 16'h0001 >= s_reg.tx_per)
      begin
        s_next.tx_cnt = 16'h0000;
        if (s_reg.ctrl[pom_pkg::IDLE_B])
        begin
          s_next.tx_word  = txw & pom_pkg::IDLE_MASK;
          s_next.tx_valid = 1'b1;
        end
        else if (steady_state)
        begin
          s_next.tx_word  = txw;
          s_next.tx_valid = 1'b1;
        end
        s_next.line_acc = line_anom;
      end
      else
        s_next.tx_cnt = s_reg.tx_cnt + 16'h0001;
    end

    // Soft clear wipes primitives, timers and indicators, keeps setup
    if (soft_clr)
    begin
      s_next          = '0;
      s_next.ctrl     = hwdata[pom_pkg::CTRL_W-1:0];
      s_next.pkt_set  = s_reg.pkt_set;
      s_next.pkt_clr  = s_reg.pkt_clr;
      s_next.mon_per  = s_reg.mon_per;
      s_next.tx_per   = s_reg.tx_per;
      s_next.ap_val   = hsel & hready & htrans[1];
      s_next.ap_wr    = hwrite;
      s_next.ap_addr  = haddr[pom_pkg::ADDR_W-1:0];
      s_next.rdata    = pom_rd(s_reg, haddr[pom_pkg::ADDR_W-1:0]);
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      s_reg         <= '0;
      s_reg.ctrl    <= pom_pkg::CTRL_RST;
      s_reg.pkt_set <= pom_pkg::PKT_SET_RST;
      s_reg.pkt_clr <= pom_pkg::PKT_CLR_RST;
      s_reg.mon_per <= pom_pkg::MON_PER_RST;
      s_reg.tx_per  <= pom_pkg::TX_PER_RST;
    end
    else
      s_reg <= s_next;
  end

  ////////////////////////////////////////////////////////////////////////////
  assign hrdata                  = s_reg.rdata;
  assign hreadyout               = 1'b1;
  assign hresp                   = 1'b0;
  assign packet_error_event      = s_reg.per_ev;
  assign far_packet_error_event  = s_reg.fper_ev;
  assign packet_error_defect     = s_reg.per_def;
  assign far_packet_error_defect = s_reg.fper_def;
  assign signal_loss_defect      = s_reg.los;
  assign supply_loss_event       = s_reg.lpr_ev;
  assign supply_loss_failure     = s_reg.lpr_fail;
  assign power_off_failure       = s_reg.pro_fail;
  assign far_supply_loss_event   = s_reg.flpr_ev;
  assign far_supply_loss_failure = s_reg.flpr_fail;
  assign far_power_off_failure   = s_reg.fpo_fail;
  assign power_ind               = s_reg.pwr_ind;
  assign tx_word                 = s_reg.tx_word;
  assign tx_valid                = s_reg.tx_valid;

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  logic clr_d;
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      clr_d <= 1'b0;
    else
      clr_d <= soft_clr;
  end

  pkt_event_a: assert property (ch_en[0] && !soft_clr
                                |=> packet_error_event[0] == $past(fcs_err[0]))
    else $error("packet error event does not follow frame check");
  far_pkt_a: assert property (ch_en[1] && !soft_clr && !far_per_ind[1]
                              |=> !far_packet_error_event[1])
    else $error("far packet error not released on zero indicator");
  chan_off_a: assert property (!ch_en[1] && !soft_clr |=> !packet_error_defect[1])
    else $error("disabled channel holds a defect");
  supply_ev_a: assert property (!soft_clr |=> supply_loss_event == $past(supply_fail))
    else $error("supply loss event does not track input");
  supply_fail_a: assert property ($rose(supply_loss_failure) && !clr_d
                                  |-> $past(s_reg.lpr_ev) &&
                                      $past(s_reg.lpr_cnt) == pom_pkg::POWER_SET_T - 16'h0001)
    else $error("supply loss failure declared early");
  pro_off_a: assert property (!s_reg.ctrl[pom_pkg::PRO_SUP_B] |=> !power_off_failure)
    else $error("power off failure without support");
  remote_far_a: assert property (!co |=> !far_supply_loss_failure && !far_power_off_failure)
    else $error("far power failure shown on remote unit");
  fpo_set_a: assert property (co && s_reg.ctrl[pom_pkg::FPO_SUP_B] && far_pro_ind && !soft_clr
                              |=> far_power_off_failure)
    else $error("far power off not declared on report");
  idle_word_a: assert property (tx_valid && $past(s_reg.ctrl[pom_pkg::IDLE_B])
                                |-> (tx_word & ~pom_pkg::IDLE_MASK) == 14'h0000)
    else $error("idle indicator word carries extra bits");
  period_cap_a: assert property ($changed(power_ind) && !clr_d |-> $past(s_reg.tick))
    else $error("power indicator changed outside period end");

endmodule : pom_monitor

/* File: testbench/pom_peer.sv */
/*
  Peer transceiver model for the packet and power monitor.
  Assumes the bench steers the peer's reports; the last word sent to it is kept and every word is counted.
*/
module pom_peer
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        idle,
  input  wire logic [1:0]  per_rep,
  input  wire logic [1:0]  pdef_rep,
  input  wire logic        lpr_rep,
  input  wire logic        pro_rep,
  input  wire logic [13:0] tx_word,
  input  wire logic        tx_valid,
  output logic      [1:0]  far_per_ind,
  output logic      [1:0]  far_pdef_ind,
  output logic             far_lpr_ind,
  output logic             far_pro_ind,
  output logic      [13:0] last_word,
  output logic      [15:0] word_cnt
);
  //////////////////////////////////////////////////////////////////////////////
  // In power saving only the supply-loss and power-off reports still travel
  assign far_per_ind  = idle ? 2'h0 : per_rep;
  assign far_pdef_ind = idle ? 2'h0 : pdef_rep;
  assign far_lpr_ind  = lpr_rep;
  assign far_pro_ind  = pro_rep;
  //////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      last_word <= 14'h0;
      word_cnt  <= 16'h0;
    end
    else if (tx_valid)
    begin
      last_word <= tx_word;
      word_cnt  <= word_cnt + 16'h1;
    end
  end
endmodule : pom_peer

/* File: testbench/pom_monitor_bench.sv */
/*
  Self-checking bench for the packet and power monitor with its peer model.
  Assumes TICK_CYCLES of 5, so one tick is five 50 MHz clocks.
*/
module pom_monitor_bench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int TK = 5;
  logic        hclk, hresetn, hsel, hwrite, hreadyout, supply_fail, power_switch_off;
  logic        far_lpr_ind, far_pro_ind, steady_state, rx_pwr_valid, signal_loss_defect;
  logic        supply_loss_event, supply_loss_failure, power_off_failure, tx_valid;
  logic        far_supply_loss_event, far_supply_loss_failure, far_power_off_failure;
  logic        lpr_rep, pro_rep, got, hresp, sef_defect, ncd_anom, hec_anom;
  logic [1:0]  htrans, fcs_err, far_per_ind, far_pdef_ind, pkt_loss_defect, per_rep, pdef_rep;
  logic [1:0]  packet_error_event, far_packet_error_event, packet_error_defect;
  logic [1:0]  far_packet_error_defect;
  logic [2:0]  hsize;
  logic [3:0]  line_anom;
  logic [5:0]  power_ind;
  logic [11:0] rx_pwr_qdb;
  logic [13:0] tx_word, last_word;
  logic [15:0] rnd, word_cnt;
  logic [31:0] haddr, hwdata, hrdata, rd, ctrl;
  int          err_count, checks_done;
  //////////////////////////////////////////////////////////////////////////////
  pom_monitor #(.TICK_CYCLES(TK), .NCH(2)) pom_monitor_i (.hclk, .hresetn, .hsel, .haddr,
    .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp,
    .fcs_err, .far_per_ind, .far_pdef_ind, .pkt_loss_defect, .supply_fail, .power_switch_off,
    .far_lpr_ind, .far_pro_ind, .line_anom, .sef_defect, .ncd_anom,
    .hec_anom, .steady_state, .rx_pwr_qdb, .rx_pwr_valid, .packet_error_event,
    .far_packet_error_event, .packet_error_defect, .far_packet_error_defect,
    .signal_loss_defect, .supply_loss_event, .supply_loss_failure, .power_off_failure,
    .far_supply_loss_event, .far_supply_loss_failure, .far_power_off_failure, .power_ind,
    .tx_word, .tx_valid);
  pom_peer pom_peer_i (.hclk, .hresetn, .idle(ctrl[5]), .per_rep, .pdef_rep, .lpr_rep,
    .pro_rep, .tx_word, .tx_valid, .far_per_ind, .far_pdef_ind, .far_lpr_ind, .far_pro_ind,
    .last_word, .word_cnt);
  //////////////////////////////////////////////////////////////////////////////
  function automatic logic [15:0] lfsr(logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr
  // A disabled channel keeps all its outputs low
  function automatic logic [31:0] ev_exp(logic [1:0] v, logic [31:0] c);
    return {30'h0, v & c[1:0]};
  endfunction : ev_exp
  task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : end_of_test
  task automatic cyc(int n);
    repeat (n) @(posedge hclk);
    #1;
  endtask : cyc
  task automatic rdy();
    int n;
    n = 0;
    do
    begin
      @(posedge hclk);
      n++;
    end
    while (hreadyout !== 1'b1 && n < 20);
    if (hreadyout !== 1'b1)
    begin
      err_count++;
      end_of_test();
    end
  endtask : rdy
  task automatic bus(logic wr, logic [7:0] a, logic [31:0] d);
    @(posedge hclk);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr  <= {24'h0, a};
    rdy();
    htrans <= 2'h0;
    hsel   <= 1'b0;
    hwdata <= d;
    rdy();
    rd = hrdata;
    chk("hresp", 32'(hresp), 32'h0);
  endtask : bus
  task automatic wait_tx(logic want);
    int n;
    n = 0;
    got = 1'b0;
    while (!got && n < 30 * TK)
    begin
      cyc(1);
      got = (tx_valid === 1'b1);
      n++;
    end
    if (want && !got)
    begin
      err_count++;
      end_of_test();
    end
  endtask : wait_tx
  task automatic pwr(logic [11:0] v);
    @(posedge hclk);
    rx_pwr_qdb   <= v;
    rx_pwr_valid <= 1'b1;
    @(posedge hclk);
    rx_pwr_valid <= 1'b0;
    cyc(2);
  endtask : pwr
  //////////////////////////////////////////////////////////////////////////////
  initial
  begin
    hclk = 1'b0;
    forever #10 hclk = ~hclk;
  end
  initial
  begin
    {hresetn, hsel, hwrite, htrans, haddr, hwdata, fcs_err, per_rep, pdef_rep} = '0;
    {pkt_loss_defect, supply_fail, power_switch_off, lpr_rep, pro_rep, line_anom} = '0;
    {sef_defect, ncd_anom, hec_anom} = '0;
    {steady_state, rx_pwr_qdb, rx_pwr_valid, err_count, checks_done} = '0;
    hsize = 3'h2;
    rnd = 16'h001d;
    ctrl = 32'h7;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    bus(1'b0, pom_pkg::CTRL_OFS, 32'h0);
    chk("ctrl", rd, {26'h0, pom_pkg::CTRL_RST});
    bus(1'b0, pom_pkg::MON_PER_OFS, 32'h0);
    chk("mon_per", rd, {16'h0, pom_pkg::MON_PER_RST});
    bus(1'b1, pom_pkg::STATUS_OFS, 32'hffffffff);
    bus(1'b0, pom_pkg::STATUS_OFS, 32'h0);
    chk("status", rd, 32'h0);
    bus(1'b0, 8'h40, 32'h0);
    chk("unmapped", rd, 32'h0);
    bus(1'b1, pom_pkg::PKT_SET_OFS, 32'h4);
    bus(1'b1, pom_pkg::PKT_CLR_OFS, 32'h4);
    bus(1'b1, pom_pkg::MON_PER_OFS, 32'h14);
    bus(1'b1, pom_pkg::TX_PER_OFS, 32'ha);
    bus(1'b0, pom_pkg::TX_PER_OFS, 32'h0);
    chk("tx_per", rd, 32'ha);
    $display("test registers done");
    for (int k = 0; k < 2; k++)
    begin
      ctrl = (k == 0) ? 32'h7 : 32'h6;
      bus(1'b1, pom_pkg::CTRL_OFS, ctrl);
      for (int i = 0; i < 20; i++)
      begin
        @(posedge hclk);
        rnd = lfsr(rnd);
        fcs_err         <= rnd[1:0];
        per_rep         <= rnd[3:2];
        line_anom       <= rnd[7:4];
        pkt_loss_defect <= rnd[9:8];
        cyc(1);
        chk("per_ev", 32'(packet_error_event), ev_exp(fcs_err, ctrl));
        chk("fper_ev", 32'(far_packet_error_event), ev_exp(per_rep, ctrl));
      end
    end
    ctrl = 32'h1f;
    bus(1'b1, pom_pkg::CTRL_OFS, ctrl);
    @(posedge hclk);
    {fcs_err, per_rep, pdef_rep} <= {2'h1, 2'h0, 2'h2};
    cyc(2 * TK);
    chk("pdef_early", 32'(packet_error_defect), 32'h0);
    chk("fpdef", 32'(far_packet_error_defect), 32'h2);
    cyc(6 * TK);
    chk("pdef", 32'(packet_error_defect), 32'h1);
    @(posedge hclk);
    {fcs_err, pdef_rep} <= 4'h0;
    cyc(2 * TK);
    chk("pdef_hold", 32'(packet_error_defect), 32'h1);
    chk("fpdef_clr", 32'(far_packet_error_defect), 32'h0);
    cyc(6 * TK);
    chk("pdef_clr", 32'(packet_error_defect), 32'h0);
    $display("test packet done");
    @(posedge hclk);
    steady_state <= 1'b1;
    pwr(12'h190);
    pwr(12'h178);
    chk("los_edge", 32'(signal_loss_defect), 32'h0);
    pwr(12'h177);
    chk("los", 32'(signal_loss_defect), 32'h1);
    @(posedge hclk);
    {supply_fail, lpr_rep, pro_rep, power_switch_off} <= 4'hf;
    cyc(2);
    chk("lpr_ev", 32'(supply_loss_event), 32'h1);
    chk("flpr_ev", 32'(far_supply_loss_event), 32'h1);
    chk("pro", 32'(power_off_failure), 32'h1);
    chk("fpo", 32'(far_power_off_failure), 32'h1);
    @(posedge hclk);
    {lpr_rep, pro_rep, power_switch_off} <= 3'h0;
    cyc(2);
    chk("pro_off", 32'(power_off_failure), 32'h0);
    cyc(2400 * TK - 6);
    chk("lpr_early", 32'({supply_loss_failure, far_supply_loss_failure}), 32'h0);
    cyc(200 * TK);
    chk("lpr_fail", 32'({supply_loss_failure, far_supply_loss_failure}), 32'h3);
    chk("pind", 32'(power_ind), 32'h33);
    @(posedge hclk);
    {supply_fail, steady_state} <= 2'h0;
    cyc(9900 * TK);
    chk("hold", 32'({supply_loss_failure, far_supply_loss_failure, far_power_off_failure}),
      32'h7);
    cyc(200 * TK);
    chk("clear", 32'({supply_loss_failure, far_supply_loss_failure, far_power_off_failure}),
      32'h0);
    cyc(50 * TK);
    chk("pind_clr", 32'(power_ind), 32'h0);
    $display("test power done");
    @(posedge hclk);
    {steady_state, pkt_loss_defect, sef_defect, ncd_anom, hec_anom} <= 6'h3f;
    wait_tx(1'b1);
    chk("far_packet_loss", 32'(tx_word[pom_pkg::TXW_FAR_PACKET_LOSS+:2]), 32'h3);
    chk("txw", 32'(tx_word), {18'h0, 2'h3, 2'h0, 2'h3, 2'h0, 2'h2, line_anom});
    ctrl = 32'h23;
    bus(1'b1, pom_pkg::CTRL_OFS, ctrl);
    @(posedge hclk);
    {steady_state, supply_fail, lpr_rep} <= 3'h3;
    cyc(2);
    chk("flpr_co", 32'(far_supply_loss_event), 32'h0);
    wait_tx(1'b1);
    cyc(1);
    chk("idle_word", 32'(last_word), 32'(1 << pom_pkg::TXW_LPR));
    ctrl = 32'h3;
    bus(1'b1, pom_pkg::CTRL_OFS, ctrl);
    wait_tx(1'b0);
    chk("no_send", 32'(got), 32'h0);
    bus(1'b1, pom_pkg::CTRL_OFS, 32'h8000_0007);
    cyc(1);
    chk("clr_pind", 32'(power_ind), 32'h0);
    bus(1'b0, pom_pkg::CTRL_OFS, 32'h0);
    chk("clr_ctrl", rd, 32'h7);
    bus(1'b0, pom_pkg::TX_PER_OFS, 32'h0);
    chk("clr_keep", rd, 32'ha);
    $display("test indicators done");
    end_of_test();
  end
endmodule : pom_monitor_bench
